/* File: core/drm_defines.svh */
// constants for the descriptor ring manager
`ifndef DRM_DEFINES_SVH
`define DRM_DEFINES_SVH
`define DRM_DESC_STRIDE 32'h0000_0010
`define DRM_DESC_ADDR_OFS 32'h0000_0000
`define DRM_DESC_STAT_OFS 32'h0000_0004
`define DRM_DESC_MISC_OFS 32'h0000_0008
`define DRM_INIT_LEN_OFS 32'h0000_0000
`define DRM_INIT_WORD_STEP 32'h0000_0004
`define DRM_OWN_BIT 31
`define DRM_TX_CODE_LSB 24
`define DRM_RX_CODE_LSB 28
`define DRM_CODE_MAX 4'h9
`define DRM_RING_MAX 10'h200
`define DRM_INIT_WORDS 2'h2
`define DRM_RST_WORD 32'h0000_0000
`define DRM_RST_IDX 9'h000
`define DRM_RST_CODE 4'h0
`endif

/* File: core/drm_pkg.sv */
// types for the descriptor ring manager
package drm_pkg;
  typedef enum logic [2:0] {
    DRM_IDLE = 3'b000,
    DRM_INIT = 3'b001,
    DRM_FSTAT = 3'b010,
    DRM_FADDR = 3'b011,
    DRM_WBACK = 3'b100
  } drm_st_t;

  typedef enum logic {
    DRM_OP_FETCH = 1'b0,
    DRM_OP_RELEASE = 1'b1
  } drm_op_t;

  typedef struct packed {
    drm_op_t op;
    logic ring;
    logic [14:0] status;
    logic [15:0] bcnt;
  } drm_cmd_t;

  typedef struct packed {
    logic owned;
    logic [31:0] buf_addr;
    logic [14:0] status;
    logic [15:0] bcnt;
  } drm_rsp_t;

  typedef struct packed {
    drm_st_t st;
    logic [1:0] wcnt;
    logic ring;
    logic [1:0][31:0] base;
    logic [1:0][3:0] code;
    logic [1:0][8:0] idx;
    logic [1:0] held;
    logic initialized;
    logic cmd_ready;
    logic init_done;
    logic rsp_valid;
    drm_rsp_t rsp;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
  } drm_state_t;
endpackage : drm_pkg

/* File: core/drm_ring_manager.sv */
// descriptor ring walker and bus master for transmit and receive rings
`timescale 1ns/1ps
`include "drm_defines.svh"

// Contract
// - A descriptor occupies three 32-bit words, twelve bytes, in both rings.
// - Descriptor slots sit 16 bytes apart so pointer bits 3..0 are zero.
// - Initialization reads both ring bases and both entry counts.
// - A ring holds at most 512 entries; its count is a power of two from 1 to 512.
// - Each entry yields a buffer address, a byte count and status bits.
// - One owner bit per descriptor gives it to the device or to the host.
// - Only the holder of a descriptor writes it or hands it over.
// - Ready low ends a bus cycle; if not high again, the next has no waits.
// - A 4-bit code gives a power-of-two count; codes above 9 mean 512.
// - Every initialization returns both descriptor pointers to their bases.
module drm_ring_manager (
  input wire logic clk, // 20 MHz bus clock
  input wire logic rst_n, // async reset, active low
  input wire logic init_start, // pulse: read init block
  input wire logic [31:0] init_block_addr, // init block address
  input wire logic cmd_valid, // engine request
  input wire drm_pkg::drm_cmd_t cmd, // engine request fields
  output logic cmd_ready, // request can be taken
  output logic rsp_valid, // pulse: request finished
  output drm_pkg::drm_rsp_t rsp, // descriptor contents
  output logic init_done, // pulse: init block read
  output logic [3:0] tx_ring_length_code, // code as written
  output logic [3:0] rx_ring_length_code, // code as written
  output logic mem_req, // bus cycle in progress
  output logic mem_we, // bus cycle is a write
  output logic [31:0] mem_addr, // bus byte address
  output logic [31:0] mem_wdata, // bus write data
  input wire logic [31:0] mem_rdata, // bus read data
  input wire logic bus_ready_low // active low cycle end
);
  drm_pkg::drm_state_t s;
  drm_pkg::drm_state_t next_s;
  logic bus_done;

  function automatic logic [9:0] ring_count(input logic [3:0] code);
    if (code > `DRM_CODE_MAX)
      ring_count = `DRM_RING_MAX;
    else
      ring_count = 10'(10'h001 << code);
  endfunction : ring_count

  function automatic logic [31:0] slot_addr(input logic [31:0] base,
                                            input logic [8:0] idx);
    slot_addr = base + {19'h0_0000, idx, 4'h0};
  endfunction : slot_addr

  assign bus_done = s.mem_req && !bus_ready_low;

  always_comb
  begin
    next_s = s;
    next_s.init_done = 1'b0;
    next_s.rsp_valid = 1'b0;
    if (bus_done)
      next_s.mem_req = 1'b0; // idle cycle lets ready return high
    else if (s.st != drm_pkg::DRM_IDLE)
      next_s.mem_req = 1'b1;
    unique case (s.st)
      drm_pkg::DRM_IDLE:
      begin
        next_s.mem_we = 1'b0;
        if (init_start)
        begin
          next_s.st = drm_pkg::DRM_INIT;
          next_s.wcnt = 2'h0;
          next_s.initialized = 1'b0;
          next_s.mem_addr = init_block_addr + `DRM_INIT_LEN_OFS;
        end
        else if (cmd_valid && s.cmd_ready)
        begin
          next_s.ring = cmd.ring;
          next_s.rsp.status = cmd.status;
          next_s.rsp.bcnt = cmd.bcnt;
          next_s.mem_addr = slot_addr(s.base[cmd.ring], s.idx[cmd.ring])
                            + `DRM_DESC_STAT_OFS;
          if (cmd.op == drm_pkg::DRM_OP_FETCH)
            next_s.st = drm_pkg::DRM_FSTAT;
          else if (s.held[cmd.ring])
          begin
            next_s.st = drm_pkg::DRM_WBACK;
            next_s.mem_we = 1'b1;
            next_s.mem_wdata = {1'b0, cmd.status, cmd.bcnt};
          end
          else
          begin
            next_s.rsp_valid = 1'b1; // not held: nothing written
            next_s.rsp.owned = 1'b0;
          end
        end
      end
      drm_pkg::DRM_INIT:
        if (bus_done)
        begin
          next_s.wcnt = 2'(s.wcnt + 2'h1);
          next_s.mem_addr = s.mem_addr + `DRM_INIT_WORD_STEP;
          unique case (s.wcnt)
            2'h0:
            begin
              next_s.code[0] = mem_rdata[`DRM_TX_CODE_LSB +: 4];
              next_s.code[1] = mem_rdata[`DRM_RX_CODE_LSB +: 4];
            end
            2'h1:
              next_s.base[0] = {mem_rdata[31:4], 4'h0};
            default:
              next_s.base[1] = {mem_rdata[31:4], 4'h0};
          endcase
          if (s.wcnt == `DRM_INIT_WORDS)
          begin
            next_s.st = drm_pkg::DRM_IDLE;
            next_s.idx = {`DRM_RST_IDX, `DRM_RST_IDX};
            next_s.held = 2'b00;
            next_s.initialized = 1'b1;
            next_s.init_done = 1'b1;
          end
        end
      drm_pkg::DRM_FSTAT:
        if (bus_done)
        begin
          next_s.rsp.status = mem_rdata[30:16];
          next_s.rsp.bcnt = mem_rdata[15:0];
          if (mem_rdata[`DRM_OWN_BIT])
          begin
            next_s.st = drm_pkg::DRM_FADDR;
            next_s.mem_addr = s.mem_addr - `DRM_DESC_STAT_OFS
                              + `DRM_DESC_ADDR_OFS;
          end
          else
          begin
            next_s.st = drm_pkg::DRM_IDLE; // host owns it, pointer kept
            next_s.rsp.owned = 1'b0;
            next_s.rsp_valid = 1'b1;
          end
        end
      drm_pkg::DRM_FADDR:
        if (bus_done)
        begin
          next_s.st = drm_pkg::DRM_IDLE;
          next_s.rsp.buf_addr = mem_rdata;
          next_s.rsp.owned = 1'b1;
          next_s.rsp_valid = 1'b1;
          next_s.held[s.ring] = 1'b1;
        end
      drm_pkg::DRM_WBACK:
        if (bus_done)
        begin
          next_s.st = drm_pkg::DRM_IDLE;
          next_s.mem_we = 1'b0;
          next_s.held[s.ring] = 1'b0;
          next_s.rsp.owned = 1'b0;
          next_s.rsp_valid = 1'b1;
          if ({1'b0, s.idx[s.ring]} ==
              10'(ring_count(s.code[s.ring]) - 10'h001))
            next_s.idx[s.ring] = `DRM_RST_IDX;
          else
            next_s.idx[s.ring] = 9'(s.idx[s.ring] + 9'h001);
        end
      default:
        next_s.st = drm_pkg::DRM_IDLE;
    endcase
    next_s.cmd_ready = (next_s.st == drm_pkg::DRM_IDLE) && next_s.initialized
                       && !next_s.rsp_valid;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign cmd_ready = s.cmd_ready;
  assign rsp_valid = s.rsp_valid;
  assign rsp = s.rsp;
  assign init_done = s.init_done;
  assign tx_ring_length_code = s.code[0];
  assign rx_ring_length_code = s.code[1];
  assign mem_req = s.mem_req;
  assign mem_we = s.mem_we;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;

  // checks
  logic [31:0] hold_ptr;
  assign hold_ptr = slot_addr(s.base[s.ring], s.idx[s.ring]);

  property p_word_in_slot;
    @(posedge clk) disable iff (!rst_n)
    s.mem_req && s.st != drm_pkg::DRM_INIT |->
      s.mem_addr[1:0] == 2'b00 && s.mem_addr[3:0] <= 4'h8;
  endproperty
  a_word_in_slot: assert property (p_word_in_slot)
    else $error("descriptor access outside its 12 bytes");

  property p_stat_addr;
    @(posedge clk) disable iff (!rst_n)
    s.st == drm_pkg::DRM_FSTAT |->
      s.mem_addr == hold_ptr + `DRM_DESC_STAT_OFS;
  endproperty
  a_stat_addr: assert property (p_stat_addr)
    else $error("status fetch not at slot plus four");

  property p_init_ptrs;
    @(posedge clk) disable iff (!rst_n)
    s.init_done |-> s.idx[0] == `DRM_RST_IDX && s.idx[1] == `DRM_RST_IDX
      && s.held == 2'b00;
  endproperty
  a_init_ptrs: assert property (p_init_ptrs)
    else $error("pointers not at base after init");

  property p_idx_range;
    @(posedge clk) disable iff (!rst_n)
    s.initialized |-> {1'b0, s.idx[0]} < ring_count(s.code[0])
      && {1'b0, s.idx[1]} < ring_count(s.code[1]);
  endproperty
  a_idx_range: assert property (p_idx_range)
    else $error("ring index beyond ring length");

  property p_host_owned_keeps;
    @(posedge clk) disable iff (!rst_n)
    s.rsp_valid && !s.rsp.owned && !s.init_done |->
      s.idx == $past(s.idx) || $past(s.st) == drm_pkg::DRM_WBACK;
  endproperty
  a_host_owned_keeps: assert property (p_host_owned_keeps)
    else $error("pointer moved on a host-owned entry");

  property p_write_only_held;
    @(posedge clk) disable iff (!rst_n)
    s.mem_req && s.mem_we |-> s.held[s.ring] && s.st == drm_pkg::DRM_WBACK;
  endproperty
  a_write_only_held: assert property (p_write_only_held)
    else $error("write to a descriptor the device does not hold");

  property p_ready_ends;
    @(posedge clk) disable iff (!rst_n)
    s.mem_req && !bus_ready_low |=> !s.mem_req ##1 (s.mem_req || s.st ==
      drm_pkg::DRM_IDLE);
  endproperty
  a_ready_ends: assert property (p_ready_ends)
    else $error("bus cycle not ended on ready");

  property p_handback;
    @(posedge clk) disable iff (!rst_n)
    s.mem_req && s.mem_we |-> !s.mem_wdata[31];
  endproperty
  a_handback: assert property (p_handback)
    else $error("write-back leaves owner bit with device");

  property p_wrap;
    @(posedge clk) disable iff (!rst_n)
    s.st == drm_pkg::DRM_WBACK && bus_done && !s.ring &&
      {1'b0, s.idx[0]} == 10'(ring_count(s.code[0]) - 10'h001)
      |=> s.idx[0] == 9'h000;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("transmit pointer did not wrap");

  c_init: cover property (@(posedge clk) disable iff (!rst_n) s.init_done);
  c_owned: cover property (@(posedge clk) disable iff (!rst_n)
    s.rsp_valid && s.rsp.owned);
  c_host: cover property (@(posedge clk) disable iff (!rst_n)
    $past(s.st) == drm_pkg::DRM_FSTAT && s.rsp_valid && !s.rsp.owned);
  c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
    $past(s.st) == drm_pkg::DRM_WBACK && s.idx[0] == 9'h000 &&
    $past(s.idx[0]) != 9'h000);
endmodule : drm_ring_manager

/* File: verification/drm_host_mem.sv */
// host memory and bus responder facing the descriptor ring manager
`timescale 1ns/1ps
module drm_host_mem (
  input wire logic clk, // bus clock
  input wire logic mem_req, // bus cycle open
  input wire logic mem_we, // write cycle
  input wire logic [31:0] mem_addr, // byte address
  input wire logic [31:0] mem_wdata, // write data
  input wire logic [3:0] waits, // wait states to insert
  input wire logic stuck, // keep ready low between cycles
  output logic [31:0] mem_rdata, // read data
  output logic bus_ready_low // cycle end, active low
);
  logic [31:0] words [0:63];
  logic [3:0] cnt = 4'h0;
  logic [31:0] last = 32'h0000_0000;
  logic ending;
  assign ending = mem_req && (cnt == waits || stuck);
  // low in the ending cycle; stuck leaves it low so the next cycle is 0-wait
  assign bus_ready_low = !(ending || stuck);
  // stale data inverted so a late sample cannot match by luck
  assign mem_rdata = ending ? words[mem_addr[7:2]] : ~last;
  always @(posedge clk)
  begin
    cnt <= (ending || !mem_req) ? 4'h0 : cnt + 4'h1;
    if (ending)
      last <= words[mem_addr[7:2]];
    if (ending && mem_we)
      words[mem_addr[7:2]] <= mem_wdata;
  end
endmodule : drm_host_mem

/* File: verification/test_drm_ring_manager.sv */
// self-checking testbench for the descriptor ring manager
`timescale 1ns/1ps
module test_drm_ring_manager;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic init_start = 1'b0;
  logic cmd_valid = 1'b0;
  logic [31:0] init_block_addr = 32'h0000_0000;
  drm_pkg::drm_cmd_t cmd = '0;
  logic cmd_ready, rsp_valid, init_done, mem_req, mem_we, bus_ready_low;
  drm_pkg::drm_rsp_t rsp;
  logic [3:0] tx_ring_length_code, rx_ring_length_code;
  logic [3:0] waits = 4'h0;
  logic stuck = 1'b0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  int n_fail = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  drm_ring_manager uut (.clk(clk), .rst_n(rst_n), .init_start(init_start),
    .init_block_addr(init_block_addr), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .init_done(init_done), .tx_ring_length_code(tx_ring_length_code),
    .rx_ring_length_code(rx_ring_length_code), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .bus_ready_low(bus_ready_low));
  drm_host_mem mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .waits(waits), .stuck(stuck),
    .mem_rdata(mem_rdata), .bus_ready_low(bus_ready_low));

  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_high(ref logic sig);
    int i;
    for (i = 0; i < 100; i++)
    begin
      @(posedge clk);
      if (sig)
        break;
    end
    if (i == 100)
    begin
      n_fail++;
      give_verdict();
    end
  endtask : wait_high

  // host writes only slots it holds; even counts keep chains legal
  task automatic set_desc(input int w, input logic own,
      input logic [31:0] ba, input logic [15:0] bc);
    mem.words[w] = ba;
    mem.words[w + 1] = {own, 15'h2a5a, bc};
  endtask : set_desc

  task automatic run_init(input logic [3:0] w, input logic [3:0] rx);
    mem.words[0] = {rx, 4'h1, 24'h00_0000};
    waits <= w;
    init_start <= 1'b1;
    @(posedge clk);
    init_start <= 1'b0;
    wait_high(init_done);
    check(tx_ring_length_code, 4'h1);
    check(rx_ring_length_code, rx);
  endtask : run_init

  task automatic do_cmd(input drm_pkg::drm_op_t op, input logic ring,
      input logic [14:0] st, input logic [15:0] bc);
    cmd_valid <= 1'b1;
    cmd <= '{op, ring, st, bc};
    wait_high(cmd_ready);
    cmd_valid <= 1'b0;
    wait_high(rsp_valid);
  endtask : do_cmd

  task automatic t_host_owned;
    set_desc(16, 1'b0, 32'h1000_0000, 16'h0040);
    do_cmd(drm_pkg::DRM_OP_FETCH, 1'b0, 15'h0000, 16'h0000);
    check(rsp.owned, 1'b0);
    set_desc(16, 1'b1, 32'h1000_0000, 16'h0040);
    do_cmd(drm_pkg::DRM_OP_FETCH, 1'b0, 15'h0000, 16'h0000);
    check(rsp, {1'b1, 32'h1000_0000, 15'h2a5a, 16'h0040});
  endtask : t_host_owned

  task automatic t_release_wrap;
    do_cmd(drm_pkg::DRM_OP_RELEASE, 1'b0, 15'h0155, 16'h003c);
    check(rsp.owned, 1'b0);
    check(mem.words[17], {1'b0, 15'h0155, 16'h003c});
    do_cmd(drm_pkg::DRM_OP_RELEASE, 1'b0, 15'h0011, 16'h0002);
    check(rsp.owned, 1'b0);
    check(mem.words[17], {1'b0, 15'h0155, 16'h003c});
    set_desc(20, 1'b1, 32'h2000_0000, 16'h0020);
    do_cmd(drm_pkg::DRM_OP_FETCH, 1'b0, 15'h0000, 16'h0000);
    check(rsp.buf_addr, 32'h2000_0000);
    do_cmd(drm_pkg::DRM_OP_RELEASE, 1'b0, 15'h0003, 16'h0010);
    check(mem.words[21], {1'b0, 15'h0003, 16'h0010});
    set_desc(16, 1'b1, 32'h3000_0000, 16'h0008);
    do_cmd(drm_pkg::DRM_OP_FETCH, 1'b0, 15'h0000, 16'h0000);
    check(rsp.buf_addr, 32'h3000_0000);
    do_cmd(drm_pkg::DRM_OP_RELEASE, 1'b0, 15'h0003, 16'h0010);
    check(mem.words[17], {1'b0, 15'h0003, 16'h0010});
  endtask : t_release_wrap

  // slow bus and a second init; pointers must restart at the bases
  task automatic t_reinit;
    run_init(4'h2, 4'ha);
    set_desc(16, 1'b1, 32'h4000_0000, 16'h0004);
    do_cmd(drm_pkg::DRM_OP_FETCH, 1'b0, 15'h0000, 16'h0000);
    check(rsp.buf_addr, 32'h4000_0000);
    set_desc(32, 1'b1, 32'h5000_0000, 16'h0100);
    do_cmd(drm_pkg::DRM_OP_FETCH, 1'b1, 15'h0000, 16'h0000);
    check(rsp, {1'b1, 32'h5000_0000, 15'h2a5a, 16'h0100});
    do_cmd(drm_pkg::DRM_OP_RELEASE, 1'b1, 15'h0007, 16'h00fe);
    check(mem.words[33], {1'b0, 15'h0007, 16'h00fe});
  endtask : t_reinit

  // ready never returns high: both reads of a fetch end with no waits
  task automatic t_stuck_ready;
    int n;
    set_desc(36, 1'b1, 32'h6000_0000, 16'h0002);
    waits <= 4'h3;
    stuck <= 1'b1;
    cmd_valid <= 1'b1;
    cmd <= '{drm_pkg::DRM_OP_FETCH, 1'b1, 15'h0000, 16'h0000};
    wait_high(cmd_ready);
    cmd_valid <= 1'b0;
    for (n = 0; n < 20 && !rsp_valid; n++)
      @(posedge clk);
    stuck <= 1'b0;
    if (n == 20)
    begin
      n_fail++;
      give_verdict();
    end
    check(n, 5);
    check(rsp, {1'b1, 32'h6000_0000, 15'h2a5a, 16'h0002});
  endtask : t_stuck_ready

  initial
  begin
    mem.words[1] = 32'h0000_0040;
    mem.words[2] = 32'h0000_0080;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    run_init(4'h0, 4'hf);
    t_host_owned();
    t_release_wrap();
    t_reinit();
    t_stuck_ready();
    give_verdict();
  end
endmodule : test_drm_ring_manager
